// file: logic/rccr_defs.svh
// Offsets, field positions and reset values of the reset/clock registers.
// Assumes a 32-bit APB slave that decodes byte addresses.
`ifndef RCCR_DEFS_SVH
`define RCCR_DEFS_SVH
`define RCCR_ADDR_W        12
`define RCCR_OFS_RSTSCK    12'h024
`define RCCR_OFS_PERRST    12'h028
`define RCCR_OFS_PREDIV    12'h02C
`define RCCR_OFS_KCLKSEL   12'h030
`define RCCR_OFS_VKEY      12'h100
`define RCCR_OFS_DSV       12'h134
`define RCCR_BIT_BORF      17
`define RCCR_BIT_RESET_FLAGS_CLEAR     24
`define RCCR_BIT_PLLRE     14
`define RCCR_BIT_HXRE      13
`define RCCR_BIT_ECCRE     12
`define RCCR_BIT_LVDRE     11
`define RCCR_BIT_LOCKRE    10
`define RCCR_BIT_OSCSTB    1
`define RCCR_BIT_OSCEN     0
`define RCCR_PERRST_MASK   32'h007E404B
`define RCCR_GPIO_LSB      17
`define RCCR_GPIO_MSB      22
`define RCCR_BIT_MFCRST    14
`define RCCR_BIT_CHECKSUM_UNIT_RESET    6
`define RCCR_BIT_DMUXRST   3
`define RCCR_BIT_SECOND_DMA_RESET   1
`define RCCR_BIT_FIRST_DMA_RESET   0
`define RCCR_PREDIV_MSB    3
`define RCCR_ADC_CLOCK_PRESCALER_MSB    31
`define RCCR_ADC_CLOCK_PRESCALER_LSB    27
`define RCCR_ADC_DIV_OFS   6'h02
`define RCCR_KCLK_MASK     32'hF800F0F3
`define RCCR_UNLOCK_KEY    32'h1A2B3C4D
`define RCCR_DSV_RESET     2'h3
`define RCCR_NUM_SYNC      7
`endif

// file: logic/rccr_pkg.sv
// Types shared by the reset/clock register block.
// Assumes the defines header is compiled alongside.
package rccr_pkg;
  // CAN kernel clock source codes
  typedef enum logic [1:0] {
    RCCR_CAN_HXTAL = 2'h0,
    RCCR_CAN_APB2  = 2'h1,
    RCCR_CAN_APB2H = 2'h2,
    RCCR_CAN_IRC8M = 2'h3
  } rccr_can_src_e;
  // Serial kernel clock source codes
  typedef enum logic [1:0] {
    RCCR_SER_HXTAL = 2'h0,
    RCCR_SER_SYS   = 2'h1,
    RCCR_SER_LXTAL = 2'h2,
    RCCR_SER_IRC8M = 2'h3
  } rccr_ser_src_e;
  // Kernel clock selections as one bundle
  typedef struct packed {
    rccr_can_src_e can_b_clock_select;
    rccr_can_src_e can_a_clock_select;
    rccr_ser_src_e serial_c_clock_select;
    rccr_ser_src_e serial_b_clock_select;
    rccr_ser_src_e serial_a_clock_select;
  } rccr_kclk_s;
  // Peripheral reset lines
  typedef struct packed {
    logic [5:0] gpio_reset;
    logic       multifunc_comm_reset;
    logic       checksum_unit_reset;
    logic       dma_request_mux_reset;
    logic       second_dma_reset;
    logic       first_dma_reset;
  } rccr_perrst_s;
endpackage

// file: logic/rccr_regs.sv
// Reset-source, peripheral-reset and clock-config registers on APB.
// Assumes monitor/error inputs come from other domains and are synced.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rccr_defs.svh"
module rccr_regs
  import rccr_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        BOR_EVENT,
  input  wire logic        PLL_MON_ERR,
  input  wire logic        HXTAL_MON_ERR,
  input  wire logic        ECC_DBL_ERR,
  input  wire logic        LVD_LOW,
  input  wire logic        CPU_LOCKUP,
  input  wire logic        SLOW_OSC_READY,
  input  wire logic        PLL_MON_IRQ_EN,
  output var  logic        SYS_RESET_REQ,
  output var  logic        PLL_MON_IRQ,
  output var  logic        SLOW_OSC_ENABLE,
  output var  rccr_perrst_s PERIPH_RESET,
  output var  logic [3:0]  PLL_PREDIV,
  output var  logic        ADC_CLK_TICK,
  output var  rccr_kclk_s  KERNEL_CLK_SEL,
  output var  logic [1:0]  DEEP_SLEEP_VSEL
);

  logic [6:0]  sync1_q;
  logic [6:0]  sync2_q;
  logic        bor_s;
  logic        bor_d1_q;
  logic        pll_err_s;
  logic        hx_err_s;
  logic        ecc_err_s;
  logic        lvd_s;
  logic        lock_s;
  logic        osc_rdy_s;
  logic        brownout_reset_flag_q;
  logic [4:0]  rst_en_q;
  logic        slow_osc_enable_q;
  logic [31:0] perrst_q;
  logic [3:0]  prediv_q;
  logic [31:0] kclk_q;
  logic [1:0]  dsv_q;
  logic        unlock_q;
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic        flag_clr;
  logic [31:0] rd_mux;
  logic [5:0]  adc_cnt_q;
  logic [5:0]  adc_div;
  logic        sys_rst_q;
  logic        pll_irq_q;
  logic        tick_q;

  // Two-flop synchronisers for all asynchronous inputs
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {SLOW_OSC_READY, CPU_LOCKUP, LVD_LOW, ECC_DBL_ERR,
                  HXTAL_MON_ERR, PLL_MON_ERR, BOR_EVENT};
      sync2_q <= sync1_q;
    end
  end
  assign bor_s     = sync2_q[0];
  assign pll_err_s = sync2_q[1];
  assign hx_err_s  = sync2_q[2];
  assign ecc_err_s = sync2_q[3];
  assign lvd_s     = sync2_q[4];
  assign lock_s    = sync2_q[5];
  assign osc_rdy_s = sync2_q[6];

  // APB decode: zero wait states, write takes effect in access phase
  assign setup  = PSEL && !PENABLE;
  assign wr_en  = PSEL && PENABLE && PWRITE && hit;
  assign PREADY = 1'b1;
  always_comb begin
    unique case (PADDR)
      `RCCR_OFS_RSTSCK, `RCCR_OFS_PERRST, `RCCR_OFS_PREDIV,
      `RCCR_OFS_KCLKSEL, `RCCR_OFS_VKEY, `RCCR_OFS_DSV: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign flag_clr = wr_en && (PADDR == `RCCR_OFS_RSTSCK)
                    && PWDATA[`RCCR_BIT_RESET_FLAGS_CLEAR];

  // Read mux; reserved bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      `RCCR_OFS_RSTSCK: begin
        rd_mux[`RCCR_BIT_BORF]   = brownout_reset_flag_q;
        rd_mux[14:10]            = rst_en_q;
        rd_mux[`RCCR_BIT_OSCSTB] = slow_osc_enable_q && osc_rdy_s;
        rd_mux[`RCCR_BIT_OSCEN]  = slow_osc_enable_q;
      end
      `RCCR_OFS_PERRST:  rd_mux = perrst_q;
      `RCCR_OFS_PREDIV:  rd_mux[3:0] = prediv_q;
      `RCCR_OFS_KCLKSEL: rd_mux = kclk_q;
      `RCCR_OFS_VKEY:    rd_mux = 32'h0000_0000;
      `RCCR_OFS_DSV:     rd_mux[1:0] = dsv_q;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= !hit;
    end
  end

  property p_unmapped;
    @(posedge CLOCK) disable iff (!RST_B)
      setup && !hit |=> PSLVERR && PRDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      bor_d1_q              <= 1'b0;
      brownout_reset_flag_q <= 1'b0;
    end else begin
      bor_d1_q <= bor_s;
      if (bor_s && !bor_d1_q) begin
        brownout_reset_flag_q <= 1'b1;
      end else if (flag_clr) begin
        brownout_reset_flag_q <= 1'b0;
      end
    end
  end

  // Reset enables and slow oscillator enable
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_en_q          <= 5'h00;
      slow_osc_enable_q <= 1'b0;
    end else if (wr_en && PADDR == `RCCR_OFS_RSTSCK) begin
      rst_en_q          <= PWDATA[14:10];
      slow_osc_enable_q <= PWDATA[`RCCR_BIT_OSCEN];
    end
  end
  assign SLOW_OSC_ENABLE = slow_osc_enable_q;

  // Reset request and PLL monitor interrupt
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sys_rst_q <= 1'b0;
      pll_irq_q <= 1'b0;
    end else begin
      sys_rst_q <= (pll_err_s && rst_en_q[4]) || (hx_err_s && rst_en_q[3])
                || (ecc_err_s && rst_en_q[2]) || (lvd_s && rst_en_q[1])
                || (lock_s && rst_en_q[0]);
      pll_irq_q <= pll_err_s && !rst_en_q[4] && PLL_MON_IRQ_EN;
    end
  end
  assign SYS_RESET_REQ = sys_rst_q;
  assign PLL_MON_IRQ   = pll_irq_q;

  property p_ecc_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      ecc_err_s && rst_en_q[2] |=> SYS_RESET_REQ;
  endproperty
  a_ecc_rst: assert property (p_ecc_rst) else $error("ecc reset missing");

  property p_lvd_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      lvd_s && rst_en_q[1] |=> SYS_RESET_REQ;
  endproperty
  a_lvd_rst: assert property (p_lvd_rst) else $error("low voltage reset missing");

  property p_lock_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      lock_s && rst_en_q[0] |=> SYS_RESET_REQ;
  endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("lock-up reset missing");

  property p_hx_quiet;
    @(posedge CLOCK) disable iff (!RST_B)
      hx_err_s && !rst_en_q[3] && !pll_err_s && !ecc_err_s && !lvd_s && !lock_s
      |=> !SYS_RESET_REQ;
  endproperty
  a_hx_quiet: assert property (p_hx_quiet) else $error("crystal reset while off");

  property p_pll_irq;
    @(posedge CLOCK) disable iff (!RST_B)
      pll_err_s && !rst_en_q[4] && PLL_MON_IRQ_EN |=> PLL_MON_IRQ;
  endproperty
  a_pll_irq: assert property (p_pll_irq) else $error("pll interrupt missing");

  // Peripheral reset register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      perrst_q <= 32'h0000_0000;
    end else if (wr_en && PADDR == `RCCR_OFS_PERRST) begin
      perrst_q <= PWDATA & `RCCR_PERRST_MASK;
    end
  end
  // Peripheral reset lines, one process drives the whole bundle
  always_comb begin
    PERIPH_RESET.gpio_reset            = perrst_q[`RCCR_GPIO_MSB:`RCCR_GPIO_LSB];
    PERIPH_RESET.multifunc_comm_reset  = perrst_q[`RCCR_BIT_MFCRST];
    PERIPH_RESET.checksum_unit_reset   = perrst_q[`RCCR_BIT_CHECKSUM_UNIT_RESET];
    PERIPH_RESET.dma_request_mux_reset = perrst_q[`RCCR_BIT_DMUXRST];
    PERIPH_RESET.second_dma_reset      = perrst_q[`RCCR_BIT_SECOND_DMA_RESET];
    PERIPH_RESET.first_dma_reset       = perrst_q[`RCCR_BIT_FIRST_DMA_RESET];
  end

  // Predivider and kernel clock selects
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      prediv_q <= 4'h0;
      kclk_q   <= 32'h0000_0000;
    end else begin
      // predivider code, ratio is code plus one
      if (wr_en && PADDR == `RCCR_OFS_PREDIV) begin
        prediv_q <= PWDATA[`RCCR_PREDIV_MSB:0];
      end
      if (wr_en && PADDR == `RCCR_OFS_KCLKSEL) begin
        kclk_q <= PWDATA & `RCCR_KCLK_MASK;
      end
    end
  end
  assign PLL_PREDIV = prediv_q;

  property p_prediv;
    @(posedge CLOCK) disable iff (!RST_B)
      wr_en && PADDR == `RCCR_OFS_PREDIV |=> PLL_PREDIV == $past(PWDATA[3:0]);
  endproperty
  a_prediv: assert property (p_prediv) else $error("predivider not taken");

  // Kernel clock selects, one process drives the whole bundle
  always_comb begin
    KERNEL_CLK_SEL.can_b_clock_select    = rccr_can_src_e'(kclk_q[15:14]);
    KERNEL_CLK_SEL.can_a_clock_select    = rccr_can_src_e'(kclk_q[13:12]);
    KERNEL_CLK_SEL.serial_c_clock_select = rccr_ser_src_e'(kclk_q[7:6]);
    KERNEL_CLK_SEL.serial_b_clock_select = rccr_ser_src_e'(kclk_q[5:4]);
    KERNEL_CLK_SEL.serial_a_clock_select = rccr_ser_src_e'(kclk_q[1:0]);
  end

  assign adc_div = {1'b0, kclk_q[`RCCR_ADC_CLOCK_PRESCALER_MSB:`RCCR_ADC_CLOCK_PRESCALER_LSB]}
                   + `RCCR_ADC_DIV_OFS;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      adc_cnt_q <= 6'h00;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= (adc_cnt_q >= adc_div - 6'h01);
      if (adc_cnt_q >= adc_div - 6'h01) begin
        adc_cnt_q <= 6'h00;
      end else begin
        adc_cnt_q <= adc_cnt_q + 6'h01;
      end
    end
  end
  assign ADC_CLK_TICK = tick_q;

  // Unlock key and deep-sleep voltage
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      unlock_q <= 1'b0;
      dsv_q    <= `RCCR_DSV_RESET;
    end else if (wr_en && PADDR == `RCCR_OFS_VKEY) begin
      unlock_q <= (PWDATA == `RCCR_UNLOCK_KEY);
    end else if (wr_en && PADDR == `RCCR_OFS_DSV) begin
      unlock_q <= 1'b0;
      if (unlock_q) begin
        dsv_q <= PWDATA[1:0];
      end
    end
  end
  assign DEEP_SLEEP_VSEL = dsv_q;

  property p_dsv_write;
    @(posedge CLOCK) disable iff (!RST_B)
      wr_en && PADDR == `RCCR_OFS_DSV && unlock_q |=> DEEP_SLEEP_VSEL == $past(PWDATA[1:0]);
  endproperty
  a_dsv_write: assert property (p_dsv_write) else $error("keyed write lost");

  property p_bor_sticky;
    @(posedge CLOCK) disable iff (!RST_B)
      brownout_reset_flag_q && !flag_clr |=> brownout_reset_flag_q;
  endproperty
  a_bor_sticky: assert property (p_bor_sticky) else $error("flag lost");

  property p_clr;
    @(posedge CLOCK) disable iff (!RST_B)
      flag_clr && !(bor_s && !bor_d1_q) |=> !brownout_reset_flag_q;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");

  property p_pll_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      pll_err_s && rst_en_q[4] |=> SYS_RESET_REQ && !PLL_MON_IRQ;
  endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("pll reset missing");

  property p_hx_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      hx_err_s && rst_en_q[3] |=> SYS_RESET_REQ;
  endproperty
  a_hx_rst: assert property (p_hx_rst) else $error("hxtal reset missing");

  property p_no_rst;
    @(posedge CLOCK) disable iff (!RST_B)
      !pll_err_s && !hx_err_s && !ecc_err_s && !lvd_s && !lock_s
      |=> !SYS_RESET_REQ;
  endproperty
  a_no_rst: assert property (p_no_rst) else $error("spurious reset");

  property p_osc_stb;
    @(posedge CLOCK) disable iff (!RST_B)
      setup && !PWRITE && PADDR == `RCCR_OFS_RSTSCK && !slow_osc_enable_q
      |=> !PRDATA[`RCCR_BIT_OSCSTB];
  endproperty
  a_osc_stb: assert property (p_osc_stb) else $error("stable while off");

  property p_key_rd;
    @(posedge CLOCK) disable iff (!RST_B)
      setup && !PWRITE && PADDR == `RCCR_OFS_VKEY |=> PRDATA == 32'h0;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read nonzero");

  property p_dsv_lock;
    @(posedge CLOCK) disable iff (!RST_B)
      wr_en && PADDR == `RCCR_OFS_DSV && !unlock_q |=> $stable(dsv_q);
  endproperty
  a_dsv_lock: assert property (p_dsv_lock) else $error("locked write");

  property p_adc_tick;
    @(posedge CLOCK) disable iff (!RST_B)
      ADC_CLK_TICK && $stable(kclk_q) |=> !ADC_CLK_TICK;
  endproperty
  a_adc_tick: assert property (p_adc_tick) else $error("tick too close");

endmodule // rccr_regs
`default_nettype wire

// file: testbench/reset_clock_config_regs_bench.sv
// Self-checking bench for the reset/clock register block over APB.
// Assumes rccr_pkg, the defines header and rccr_regs are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "rccr_defs.svh"
module reset_clock_config_regs_bench
  import rccr_pkg::*;
;
  logic         CLOCK = 1'b0;
  logic         RST_B = 1'b0;
  logic         PSEL = 1'b0;
  logic         PENABLE = 1'b0;
  logic         PWRITE = 1'b0;
  logic [11:0]  PADDR = 12'h000;
  logic [31:0]  PWDATA = 32'h00000000;
  logic [31:0]  PRDATA;
  logic         PREADY;
  logic         PSLVERR;
  logic         BOR_EVENT = 1'b0;
  logic [4:0]   ERRS = 5'h00;
  logic         SLOW_OSC_READY = 1'b0;
  logic         PLL_MON_IRQ_EN = 1'b1;
  logic         SYS_RESET_REQ;
  logic         PLL_MON_IRQ;
  logic         SLOW_OSC_ENABLE;
  rccr_perrst_s PERIPH_RESET;
  logic [3:0]   PLL_PREDIV;
  logic         ADC_CLK_TICK;
  rccr_kclk_s   KERNEL_CLK_SEL;
  logic [1:0]   DEEP_SLEEP_VSEL;
  int           n_errors = 0;
  int           checks = 0;
  logic [32:0]  exp_q[$];
  logic [32:0]  e_m;
  logic [31:0]  d;
  int           i;
  int           t;
  logic [4:0]   p;

  rccr_regs uut (
    .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BOR_EVENT(BOR_EVENT), .PLL_MON_ERR(ERRS[4]), .HXTAL_MON_ERR(ERRS[3]),
    .ECC_DBL_ERR(ERRS[2]), .LVD_LOW(ERRS[1]), .CPU_LOCKUP(ERRS[0]),
    .SLOW_OSC_READY(SLOW_OSC_READY), .PLL_MON_IRQ_EN(PLL_MON_IRQ_EN),
    .SYS_RESET_REQ(SYS_RESET_REQ), .PLL_MON_IRQ(PLL_MON_IRQ),
    .SLOW_OSC_ENABLE(SLOW_OSC_ENABLE), .PERIPH_RESET(PERIPH_RESET),
    .PLL_PREDIV(PLL_PREDIV), .ADC_CLK_TICK(ADC_CLK_TICK),
    .KERNEL_CLK_SEL(KERNEL_CLK_SEL), .DEEP_SLEEP_VSEL(DEEP_SLEEP_VSEL)
  );

  // Clock of 8 ns period
  always #4 CLOCK = ~CLOCK;

  task results();
    $display("Errors: %0d, checks: %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; a read leaves its expectation in the queue
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
    int n;
    if (!w) exp_q.push_back(e);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge CLOCK); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin n_errors++; $display("Error at %0t: no ready", $time); results(); end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h000000000);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h00000000, e);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin n_errors++; $display("Error at %0t: port %0h not %0h", $time, g, e); end
  endtask

  // Lets synchronised inputs reach the outputs, ends mid-cycle
  task settle();
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask

  // Cycles from now to the next ADC tick
  task gap(output int n);
    n = 0;
    do begin @(negedge CLOCK); n++; end while (ADC_CLK_TICK !== 1'b1 && n < 100);
    if (n >= 100) begin n_errors++; $display("Error at %0t: no tick", $time); results(); end
  endtask

  // Read monitor: oldest note against error flag and data
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
      e_m = exp_q.size() > 0 ? exp_q.pop_front() : {33{1'bx}};
      checks++;
      if ({PSLVERR, PRDATA} !== e_m) begin
        n_errors++;
        $display("Error at %0t: read %0h not %0h", $time, {PSLVERR, PRDATA}, e_m);
      end
    end
  end

  // Hang guard
  initial begin
    #400000;
    n_errors++;
    $display("Error at %0t: run too long", $time);
    results();
  end

  initial begin
    repeat (8) @(posedge CLOCK);
    RST_B <= 1'b1;
    void'($urandom(50));
    rd(`RCCR_OFS_RSTSCK, 33'h000000000);
    rd(`RCCR_OFS_PERRST, 33'h000000000);
    rd(`RCCR_OFS_PREDIV, 33'h000000000);
    rd(`RCCR_OFS_KCLKSEL, 33'h000000000);
    rd(`RCCR_OFS_DSV, 33'h000000003);
    rd(12'h200, 33'h100000000);
    for (i = 0; i < 7; i++) begin
      d = (i < 4) ? {16{i[1:0]}} : $urandom();
      if (d[31:27] == 5'h1F) d[31] = 1'b0;
      wr(`RCCR_OFS_PERRST, d);
      rd(`RCCR_OFS_PERRST, {1'b0, d & `RCCR_PERRST_MASK});
      chk(PERIPH_RESET, {d[22:17], d[14], d[6], d[3], d[1], d[0]});
      wr(`RCCR_OFS_PREDIV, d);
      rd(`RCCR_OFS_PREDIV, {29'h00000000, d[3:0]});
      chk(PLL_PREDIV, d[3:0]);
      wr(`RCCR_OFS_KCLKSEL, d);
      rd(`RCCR_OFS_KCLKSEL, {1'b0, d & `RCCR_KCLK_MASK});
      chk(KERNEL_CLK_SEL, {d[15:12], d[7:4], d[1:0]});
    end
    for (i = 0; i < 2; i++) begin
      p = (i == 0) ? 5'h00 : 5'($urandom_range(30, 1));
      wr(`RCCR_OFS_KCLKSEL, {p, 27'h0000000});
      repeat (3) gap(t);
      chk(t, p + 32'h00000002);
      @(posedge CLOCK);
    end
    for (i = 0; i < 5; i++) begin
      wr(`RCCR_OFS_RSTSCK, 32'h00000001 << (14 - i));
      ERRS[4 - i] <= 1'b1;
      rd(`RCCR_OFS_RSTSCK, {1'b0, 32'h00000001 << (14 - i)});
      settle();
      chk(SYS_RESET_REQ, 32'h00000001);
      chk(PLL_MON_IRQ, 32'h00000000);
      wr(`RCCR_OFS_RSTSCK, 32'h00000000);
      settle();
      chk(SYS_RESET_REQ, 32'h00000000);
      chk(PLL_MON_IRQ, (i == 0));
      @(posedge CLOCK);
      PLL_MON_IRQ_EN <= 1'b0;
      settle();
      chk(PLL_MON_IRQ, 32'h00000000);
      @(posedge CLOCK);
      PLL_MON_IRQ_EN <= 1'b1;
      ERRS <= 5'h00;
      settle();
    end
    @(posedge CLOCK);
    BOR_EVENT <= 1'b1;
    settle();
    @(posedge CLOCK);
    BOR_EVENT <= 1'b0;
    settle();
    rd(`RCCR_OFS_RSTSCK, 33'h000020000);
    rd(`RCCR_OFS_RSTSCK, 33'h000020000);
    wr(`RCCR_OFS_RSTSCK, 32'h01000000);
    rd(`RCCR_OFS_RSTSCK, 33'h000000000);
    wr(`RCCR_OFS_RSTSCK, 32'h00000001);
    settle();
    chk(SLOW_OSC_ENABLE, 32'h00000001);
    rd(`RCCR_OFS_RSTSCK, 33'h000000001);
    SLOW_OSC_READY <= 1'b1;
    settle();
    rd(`RCCR_OFS_RSTSCK, 33'h000000003);
    wr(`RCCR_OFS_RSTSCK, 32'h00000000);
    settle();
    rd(`RCCR_OFS_RSTSCK, 33'h000000000);
    for (i = 0; i < 4; i++) begin
      d = ($urandom() & 32'hFFFFFFFC) | i;
      wr(`RCCR_OFS_VKEY, `RCCR_UNLOCK_KEY);
      wr(`RCCR_OFS_DSV, d);
      rd(`RCCR_OFS_VKEY, 33'h000000000);
      rd(`RCCR_OFS_DSV, {31'h00000000, i[1:0]});
      chk(DEEP_SLEEP_VSEL, i[1:0]);
      wr(`RCCR_OFS_DSV, ~d);
      rd(`RCCR_OFS_DSV, {31'h00000000, i[1:0]});
    end
    wr(`RCCR_OFS_VKEY, `RCCR_UNLOCK_KEY);
    wr(`RCCR_OFS_VKEY, `RCCR_UNLOCK_KEY ^ 32'h00000001);
    wr(`RCCR_OFS_DSV, 32'h00000000);
    rd(`RCCR_OFS_DSV, 33'h000000003);
    @(posedge CLOCK);
    @(posedge CLOCK);
    results();
  end
endmodule // reset_clock_config_regs_bench
`default_nettype wire
